/* src/dcd_command_decoder.sv */
// Command decoder core: opcode and parameter handling, sensor requests, data stream
`timescale 1ns/1ns
// Overview of operation
// - Strap low: four-wire link with select pin
// - Strap high: nine-bit frames, leading select bit
// - 10h/13h data bytes become pixel stream
// - 20h loads the 44-byte common table
// - 21h-24h each load a 42-byte table
// - 42h: attribute, high, low go to sensor
// - 43h returns sensor high then low byte
// - Select high means data, low means opcode
// - Bits count only while chip select low
// - Reset pin restores all defaults
module dcd_command_decoder (
  // System
  input wire logic clock,
  input wire logic srst,
  input wire logic hw_reset_n,
  // Host link
  input wire logic interface_strap,
  input wire logic link_sclk,
  input wire logic link_cs_n,
  input wire logic link_dc,
  input wire logic link_sdi,
  output logic link_sdo,
  output logic link_sdo_oe_n,
  output logic busy_n,
  // Stored parameters
  output logic [7:0] panel_config,
  output logic [1:0] power_rail_enables,
  output logic [2:0] power_level_select,
  output logic [5:0] positive_source_level,
  output logic [5:0] negative_source_level,
  output logic [5:0] red_source_level,
  output logic [1:0] poweroff_source_delay,
  output logic [7:0] booster_phase_a,
  output logic [7:0] booster_phase_b,
  output logic [5:0] booster_phase_c,
  output logic [5:0] frame_clock_divider,
  output logic [4:0] temp_source_select,
  output logic [7:0] temp_reading_high,
  output logic [2:0] temp_reading_low,
  // Sensor requests
  output logic sensor_write_req,
  output logic sensor_read_req,
  output logic [7:0] sensor_attr_byte,
  output logic [7:0] sensor_wr_high,
  output logic [7:0] sensor_wr_low,
  input wire logic sensor_done,
  input wire logic [7:0] sensor_rd_high,
  input wire logic [7:0] sensor_rd_low,
  // Frame and table stream
  output logic stream_valid,
  input wire logic stream_ready,
  output logic [7:0] stream_data,
  output logic [2:0] stream_target,
  output logic [12:0] stream_index
);
  logic hwr_meta, hwr_sync, rst;
  logic rx_valid, rx_dc;
  logic [7:0] rx_byte;
  dcd_pkg::dcd_state_type state, next_state;
  logic [7:0] opcode, next_opcode, pend_byte, next_pend_byte;
  logic [2:0] pidx, next_pidx;
  logic [12:0] sidx, next_sidx;
  logic pend_v, next_pend_v, pend_dc, next_pend_dc, take, in_range;
  logic [4:0] slot;
  logic [7:0] cfg [dcd_pkg::NUM_SLOTS];
  logic [7:0] next_cfg [dcd_pkg::NUM_SLOTS];
  logic next_wr_req, next_rd_req, next_busy_n;
  logic [7:0] sensor_read_high, sensor_read_low, next_sread_high, next_sread_low;
  logic [7:0] next_temp_high, read_out_high, read_out_low, next_rout_high, next_rout_low;
  logic [2:0] next_temp_low;
  logic buf_in_valid, buf_in_ready;
  logic [2:0] target;

  // Slot index and valid flag of a parameter position
  function automatic logic [4:0] slot_of(input logic [7:0] op, input logic [2:0] idx);
    logic [4:0] s;
    s = 5'h00;
    case (op)
      dcd_pkg::OP_PANEL: s = {idx == 3'h0, dcd_pkg::SLOT_PANEL};
      dcd_pkg::OP_POWER: s = {idx < 3'h5, dcd_pkg::SLOT_RAILS + {1'b0, idx}};
      dcd_pkg::OP_PWR_OFF_SEQ: s = {idx == 3'h0, dcd_pkg::SLOT_OFF_DLY};
      dcd_pkg::OP_BOOSTER: s = {idx < 3'h3, dcd_pkg::SLOT_BT_A + {1'b0, idx}};
      dcd_pkg::OP_PLL: s = {idx == 3'h0, dcd_pkg::SLOT_PLL};
      dcd_pkg::OP_TEMP_SELECT: s = {idx == 3'h0, dcd_pkg::SLOT_TSEL};
      dcd_pkg::OP_SENSOR_WRITE: s = {idx < 3'h3, dcd_pkg::SLOT_SENS_ATTR + {1'b0, idx}};
      default: s = 5'h00;
    endcase
    return s;
  endfunction

  // Opcodes whose data bytes go to the stream
  function automatic logic is_stream(input logic [7:0] op);
    return (op == dcd_pkg::OP_BW_FRAME) || (op == dcd_pkg::OP_RED_FRAME) ||
      (op >= dcd_pkg::OP_LUT_COMMON && op <= dcd_pkg::OP_LUT_LAST);
  endfunction

  // Data byte count allowed for a stream opcode
  function automatic logic [12:0] stream_limit(input logic [7:0] op);
    logic [12:0] n;
    n = dcd_pkg::LUT_PIXEL_BYTES;
    if (op == dcd_pkg::OP_BW_FRAME || op == dcd_pkg::OP_RED_FRAME) begin
      n = dcd_pkg::PIXEL_BYTES;
    end else if (op == dcd_pkg::OP_LUT_COMMON) begin
      n = dcd_pkg::LUT_COMMON_BYTES;
    end
    return n;
  endfunction

  // Reset pin passes two flops, then joins the system reset
  always_ff @(posedge clock) begin
    hwr_meta <= hw_reset_n;
    hwr_sync <= hwr_meta;
  end
  assign rst = srst | ~hwr_sync;

  dcd_link_rx u_link (
    .clock(clock),
    .rst(rst),
    .rx_valid(rx_valid),
    .rx_dc(rx_dc),
    .rx_byte(rx_byte),
    .rd_high(read_out_high),
    .rd_low(read_out_low),
    .interface_strap(interface_strap),
    .link_sclk(link_sclk),
    .link_cs_n(link_cs_n),
    .link_dc(link_dc),
    .link_sdi(link_sdi),
    .link_sdo(link_sdo),
    .link_sdo_oe_n(link_sdo_oe_n)
  );

  // Stream target follows the opcode
  always_comb begin
    target = dcd_pkg::TGT_LUT_BASE + opcode[2:0];
    if (opcode == dcd_pkg::OP_BW_FRAME) begin
      target = dcd_pkg::TGT_BW;
    end else if (opcode == dcd_pkg::OP_RED_FRAME) begin
      target = dcd_pkg::TGT_RED;
    end
  end

  dcd_pair_buf #(
    .WIDTH(24)
  ) u_buf (
    .clock(clock),
    .rst(rst),
    .in_valid(buf_in_valid),
    .in_ready(buf_in_ready),
    .in_data({pend_byte, target, sidx}),
    .out_valid(stream_valid),
    .out_ready(stream_ready),
    .out_data({stream_data, stream_target, stream_index})
  );

  // Stored parameters drive the outputs straight from their flops
  assign panel_config = cfg[0];
  assign power_rail_enables = cfg[1][1:0];
  assign power_level_select = cfg[2][2:0];
  assign positive_source_level = cfg[3][5:0];
  assign negative_source_level = cfg[4][5:0];
  assign red_source_level = cfg[5][5:0];
  assign poweroff_source_delay = cfg[6][dcd_pkg::OFF_DLY_LSB +: 2];
  assign booster_phase_a = cfg[7];
  assign booster_phase_b = cfg[8];
  assign booster_phase_c = cfg[9][5:0];
  assign frame_clock_divider = cfg[10][5:0];
  assign temp_source_select = {cfg[11][dcd_pkg::TSEL_ENABLE_BIT], cfg[11][3:0]};
  assign sensor_attr_byte = cfg[12];
  assign sensor_wr_high = cfg[13];
  assign sensor_wr_low = cfg[14];

  // A stream byte waits while the buffer is full instead of being lost
  assign slot = slot_of(opcode, pidx);
  assign in_range = sidx < stream_limit(opcode);
  assign take = pend_v && state != dcd_pkg::S_SENSOR && !(pend_dc && state == dcd_pkg::S_STREAM && in_range
    && !buf_in_ready);

  // Decoder next state
  always_comb begin
    next_state = state;
    next_opcode = opcode;
    next_pidx = pidx;
    next_sidx = sidx;
    next_cfg = cfg;
    next_pend_v = pend_v;
    next_pend_dc = pend_dc;
    next_pend_byte = pend_byte;
    next_wr_req = sensor_write_req;
    next_rd_req = sensor_read_req;
    next_sread_high = sensor_read_high;
    next_sread_low = sensor_read_low;
    next_temp_high = temp_reading_high;
    next_temp_low = temp_reading_low;
    next_rout_high = read_out_high;
    next_rout_low = read_out_low;
    buf_in_valid = 1'b0;
    if (take) begin
      next_pend_v = 1'b0;
      if (!pend_dc) begin
        // Any opcode closes the previous sequence
        next_opcode = pend_byte;
        next_pidx = 3'h0;
        next_sidx = 13'h0000;
        if (is_stream(pend_byte)) begin
          next_state = dcd_pkg::S_STREAM;
        end else if (pend_byte == dcd_pkg::OP_SENSOR_READ || pend_byte == dcd_pkg::OP_TEMP_MEASURE) begin
          next_state = dcd_pkg::S_SENSOR;
          next_rd_req = 1'b1;
        end else begin
          next_state = dcd_pkg::S_PARAM;
        end
      end else begin
        case (state)
          dcd_pkg::S_PARAM: begin
            // Surplus bytes are dropped; unsent ones keep their value
            if (slot[4]) begin
              next_cfg[slot[3:0]] = pend_byte;
            end
            if (pidx != 3'h7) begin
              next_pidx = pidx + 3'h1;
            end
            if (opcode == dcd_pkg::OP_SENSOR_WRITE && pidx == 3'h2) begin
              next_state = dcd_pkg::S_SENSOR;
              next_wr_req = 1'b1;
            end
          end
          dcd_pkg::S_STREAM: begin
            if (in_range) begin
              buf_in_valid = 1'b1;
              next_sidx = sidx + 13'h0001;
            end
          end
          default: begin
          end
        endcase
      end
    end
    // New byte last, so an arrival in the consume cycle is kept
    if (rx_valid) begin
      next_pend_v = 1'b1;
      next_pend_dc = rx_dc;
      next_pend_byte = rx_byte;
    end
    // Sensor answer ends the busy period
    if (state == dcd_pkg::S_SENSOR && sensor_done) begin
      next_wr_req = 1'b0;
      next_rd_req = 1'b0;
      next_state = dcd_pkg::S_IDLE;
      if (opcode == dcd_pkg::OP_SENSOR_READ) begin
        next_sread_high = sensor_rd_high;
        next_sread_low = sensor_rd_low;
        next_rout_high = sensor_rd_high;
        next_rout_low = sensor_rd_low;
      end else if (opcode == dcd_pkg::OP_TEMP_MEASURE) begin
        next_temp_high = sensor_rd_high;
        next_temp_low = sensor_rd_low[7:5];
        next_rout_high = sensor_rd_high;
        next_rout_low = {sensor_rd_low[7:5], 5'h00};
      end
    end
    next_busy_n = (next_state != dcd_pkg::S_SENSOR);
  end

  // Decoder registers
  always_ff @(posedge clock) begin
    if (rst) begin
      state <= dcd_pkg::S_IDLE;
      opcode <= 8'h00;
      pidx <= 3'h0;
      sidx <= 13'h0000;
      cfg <= dcd_pkg::CFG_RESET;
      pend_v <= 1'b0;
      pend_dc <= 1'b0;
      pend_byte <= 8'h00;
      sensor_write_req <= 1'b0;
      sensor_read_req <= 1'b0;
      sensor_read_high <= 8'h00;
      sensor_read_low <= 8'h00;
      temp_reading_high <= 8'h00;
      temp_reading_low <= 3'h0;
      read_out_high <= 8'h00;
      read_out_low <= 8'h00;
      busy_n <= 1'b1;
    end else begin
      state <= next_state;
      opcode <= next_opcode;
      pidx <= next_pidx;
      sidx <= next_sidx;
      cfg <= next_cfg;
      pend_v <= next_pend_v;
      pend_dc <= next_pend_dc;
      pend_byte <= next_pend_byte;
      sensor_write_req <= next_wr_req;
      sensor_read_req <= next_rd_req;
      sensor_read_high <= next_sread_high;
      sensor_read_low <= next_sread_low;
      temp_reading_high <= next_temp_high;
      temp_reading_low <= next_temp_low;
      read_out_high <= next_rout_high;
      read_out_low <= next_rout_low;
      busy_n <= next_busy_n;
    end
  end

  // Checks on the decoder
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  property p_busy_sensor;
    (state == dcd_pkg::S_SENSOR) |-> !busy_n;
  endproperty
  a_busy_sensor: assert property (p_busy_sensor) else $error("busy high during sensor access");

  property p_sensor_write;
    (take && pend_dc && state == dcd_pkg::S_PARAM && opcode == dcd_pkg::OP_SENSOR_WRITE && pidx == 3'h2)
      |=> sensor_write_req && !busy_n && sensor_wr_low == $past(pend_byte);
  endproperty
  a_sensor_write: assert property (p_sensor_write) else $error("sensor write not issued");

  property p_sensor_read;
    (take && !pend_dc && pend_byte == dcd_pkg::OP_SENSOR_READ) |=> sensor_read_req ##0 !busy_n;
  endproperty
  a_sensor_read: assert property (p_sensor_read) else $error("sensor read not issued");

  property p_read_capture;
    (state == dcd_pkg::S_SENSOR && sensor_done && opcode == dcd_pkg::OP_SENSOR_READ)
      |=> read_out_high == $past(sensor_rd_high) && read_out_low == $past(sensor_rd_low) && busy_n;
  endproperty
  a_read_capture: assert property (p_read_capture) else $error("sensor read bytes not captured");

  property p_bw_stream;
    (take && pend_dc && state == dcd_pkg::S_STREAM && opcode == dcd_pkg::OP_BW_FRAME && in_range)
      |-> buf_in_valid && target == dcd_pkg::TGT_BW ##1 sidx == $past(sidx) + 13'h0001;
  endproperty
  a_bw_stream: assert property (p_bw_stream) else $error("pixel byte not forwarded");

  property p_stream_bound;
    (state == dcd_pkg::S_STREAM) |-> sidx <= stream_limit(opcode);
  endproperty
  a_stream_bound: assert property (p_stream_bound) else $error("stream index past table length");

  property p_lut_len;
    (state == dcd_pkg::S_STREAM && opcode == dcd_pkg::OP_LUT_LAST && sidx == dcd_pkg::LUT_PIXEL_BYTES) |-> !buf_in_valid;
  endproperty
  a_lut_len: assert property (p_lut_len) else $error("table byte beyond length accepted");

  property p_opcode_restart;
    (take && !pend_dc) |=> opcode == $past(pend_byte) && pidx == 3'h0 && sidx == 13'h0000;
  endproperty
  a_opcode_restart: assert property (p_opcode_restart) else $error("opcode did not restart sequence");

  property p_surplus_param;
    (take && pend_dc && state == dcd_pkg::S_PARAM && opcode == dcd_pkg::OP_PANEL && pidx != 3'h0) |=> $stable(cfg[0]);
  endproperty
  a_surplus_param: assert property (p_surplus_param) else $error("surplus parameter changed a value");

  property p_reset_defaults;
    @(posedge clock) srst |=> panel_config == dcd_pkg::RST_PANEL && state == dcd_pkg::S_IDLE && busy_n;
  endproperty
  a_reset_defaults: assert property (p_reset_defaults) else $error("defaults not restored by reset");
endmodule // dcd_command_decoder

/* src/dcd_link_rx.sv */
// Serial link front end on the host clock, with crossing into the core clock
`timescale 1ns/1ns
module dcd_link_rx (
  // Core clock side
  input wire logic clock,
  input wire logic rst,
  output logic rx_valid,
  output logic rx_dc,
  output logic [7:0] rx_byte,
  input wire logic [7:0] rd_high,
  input wire logic [7:0] rd_low,
  // Link pins
  input wire logic interface_strap,
  input wire logic link_sclk,
  input wire logic link_cs_n,
  input wire logic link_dc,
  input wire logic link_sdi,
  output logic link_sdo,
  output logic link_sdo_oe_n
);
  logic strap_meta, strap_sync, last_bit, next_dc;
  logic [3:0] bit_cnt, next_bit_cnt, frame_bits, out_pos;
  logic [7:0] shreg, next_shreg, next_byte, out_byte;
  logic [8:0] word_hold, next_word_hold;
  logic tog, next_tog, rd_mode, next_rd_mode, rd_idx, next_rd_idx, out_bit, out_oe_n;
  logic tog_meta, tog_sync, tog_seen, link_rst, sdo_q;

  // Strap is static, so two link-clock flops are enough
  always_ff @(posedge link_sclk) begin
    strap_meta <= interface_strap;
    strap_sync <= strap_meta;
  end

  // Frame length and command/data bit per mode
  assign frame_bits = strap_sync ? dcd_pkg::BITS_3WIRE : dcd_pkg::BITS_4WIRE;
  assign last_bit = (bit_cnt == frame_bits - 4'h1);
  assign next_byte = {shreg[6:0], link_sdi};
  assign next_dc = strap_sync ? shreg[7] : link_dc;

  // Shift and word capture
  always_comb begin
    next_bit_cnt = last_bit ? 4'h0 : bit_cnt + 4'h1;
    next_shreg = next_byte;
    next_word_hold = word_hold;
    next_tog = tog;
    next_rd_mode = rd_mode;
    next_rd_idx = rd_idx;
    if (last_bit) begin
      next_word_hold = {next_dc, next_byte};
      next_tog = ~tog;
      if (!next_dc) begin
        next_rd_mode = (next_byte == dcd_pkg::OP_SENSOR_READ) || (next_byte == dcd_pkg::OP_TEMP_MEASURE);
        next_rd_idx = 1'b0;
      end else begin
        next_rd_idx = 1'b1;
      end
    end
  end

  // Chip select high holds the bit counter clear
  always_ff @(posedge link_sclk or posedge link_cs_n) begin
    if (link_cs_n) begin
      bit_cnt <= 4'h0;
    end else begin
      bit_cnt <= next_bit_cnt;
    end
  end

  // Data path needs no reset; it only loads while chip select is low, inside frames
  always_ff @(posedge link_sclk) begin
    if (!link_cs_n) begin
      shreg <= next_shreg;
      word_hold <= next_word_hold;
    end
  end

  // Toggle and read mode need a known start, else no word would ever cross
  always_ff @(posedge link_sclk or posedge link_rst) begin
    if (link_rst) begin
      tog <= 1'b0;
      rd_mode <= 1'b0;
      rd_idx <= 1'b0;
    end else if (!link_cs_n) begin
      tog <= next_tog;
      rd_mode <= next_rd_mode;
      rd_idx <= next_rd_idx;
    end
  end

  // Read data shifts out MSB first on falling edges
  assign out_byte = rd_idx ? rd_low : rd_high;
  assign out_pos = strap_sync ? bit_cnt - 4'h1 : bit_cnt;
  always_comb begin
    out_bit = out_byte[3'h7 - out_pos[2:0]];
    out_oe_n = ~(rd_mode && !(strap_sync && bit_cnt == 4'h0));
  end

  always_ff @(negedge link_sclk or posedge link_cs_n) begin
    if (link_cs_n) begin
      sdo_q <= 1'b0;
      link_sdo_oe_n <= 1'b1;
    end else begin
      sdo_q <= out_bit;
      link_sdo_oe_n <= out_oe_n;
    end
  end
  // Four-wire MSB must stand before the first rising edge, and the answer may land
  // after the opcode's last falling edge, so it bypasses the flop; stable while busy is high
  assign link_sdo = (!strap_sync && bit_cnt == 4'h0) ? out_bit : sdo_q;

  // Toggle crossing; the word holds for a whole frame after a toggle
  always_ff @(posedge clock) begin
    tog_meta <= tog;
    tog_sync <= tog_meta;
    link_rst <= rst; // Registered so the link-side reset cannot glitch
    if (rst) begin
      tog_seen <= tog_sync;
      rx_valid <= 1'b0;
      rx_dc <= 1'b0;
      rx_byte <= 8'h00;
    end else begin
      tog_seen <= tog_sync;
      rx_valid <= tog_sync ^ tog_seen;
      if (tog_sync ^ tog_seen) begin
        rx_dc <= word_hold[8];
        rx_byte <= word_hold[7:0];
      end
    end
  end
endmodule // dcd_link_rx

/* src/dcd_pair_buf.sv */
// Two-entry valid/ready buffer for the outgoing data stream
`timescale 1ns/1ns
module dcd_pair_buf #(
  parameter int WIDTH = 24
) (
  // System
  input wire logic clock,
  input wire logic rst,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  logic v0, v1, next_v0, next_v1, push, pop;
  logic [WIDTH-1:0] d0, d1, next_d0, next_d1;

  // Full is the second slot taken, so ready comes from a flop
  assign in_ready = ~v1;
  assign out_valid = v0;
  assign out_data = d0;
  assign push = in_valid & ~v1;
  assign pop = v0 & out_ready;

  // Slot bookkeeping
  always_comb begin
    next_v0 = v0;
    next_v1 = v1;
    next_d0 = d0;
    next_d1 = d1;
    if (pop) begin
      next_d0 = v1 ? d1 : in_data;
      next_v0 = v1 | push;
      next_v1 = 1'b0;
    end else if (push) begin
      if (!v0) begin
        next_d0 = in_data;
        next_v0 = 1'b1;
      end else begin
        next_d1 = in_data;
        next_v1 = 1'b1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      v0 <= 1'b0;
      v1 <= 1'b0;
      d0 <= '0;
      d1 <= '0;
    end else begin
      v0 <= next_v0;
      v1 <= next_v1;
      d0 <= next_d0;
      d1 <= next_d1;
    end
  end
endmodule // dcd_pair_buf

/* src/dcd_pkg.sv */
// Shared constants and types for the display command decoder
package dcd_pkg;
  // Opcodes the decoder recognises
  localparam logic [7:0] OP_PANEL = 8'h00;
  localparam logic [7:0] OP_POWER = 8'h01;
  localparam logic [7:0] OP_PWR_OFF_SEQ = 8'h03;
  localparam logic [7:0] OP_BOOSTER = 8'h06;
  localparam logic [7:0] OP_BW_FRAME = 8'h10;
  localparam logic [7:0] OP_RED_FRAME = 8'h13;
  localparam logic [7:0] OP_LUT_COMMON = 8'h20;
  localparam logic [7:0] OP_LUT_LAST = 8'h24;
  localparam logic [7:0] OP_PLL = 8'h30;
  localparam logic [7:0] OP_TEMP_MEASURE = 8'h40;
  localparam logic [7:0] OP_TEMP_SELECT = 8'h41;
  localparam logic [7:0] OP_SENSOR_WRITE = 8'h42;
  localparam logic [7:0] OP_SENSOR_READ = 8'h43;
  // Parameter storage slots
  localparam logic [3:0] SLOT_PANEL = 4'h0;
  localparam logic [3:0] SLOT_RAILS = 4'h1;
  localparam logic [3:0] SLOT_OFF_DLY = 4'h6;
  localparam logic [3:0] SLOT_BT_A = 4'h7;
  localparam logic [3:0] SLOT_PLL = 4'ha;
  localparam logic [3:0] SLOT_TSEL = 4'hb;
  localparam logic [3:0] SLOT_SENS_ATTR = 4'hc;
  localparam int NUM_SLOTS = 15;
  // Field positions inside stored bytes
  localparam int OFF_DLY_LSB = 4;
  localparam int TSEL_ENABLE_BIT = 7;
  // Reset values of the stored parameters
  localparam logic [7:0] RST_PANEL = 8'h0f;
  localparam logic [7:0] RST_RAILS = 8'h03;
  localparam logic [7:0] RST_LEVEL = 8'h00;
  localparam logic [7:0] RST_POS_SRC = 8'h26;
  localparam logic [7:0] RST_NEG_SRC = 8'h26;
  localparam logic [7:0] RST_RED_SRC = 8'h03;
  localparam logic [7:0] RST_OFF_DLY = 8'h00;
  localparam logic [7:0] RST_BT = 8'h17;
  localparam logic [7:0] RST_PLL = 8'h3c;
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] CFG_RESET [NUM_SLOTS] = '{RST_PANEL, RST_RAILS, RST_LEVEL, RST_POS_SRC, RST_NEG_SRC,
    RST_RED_SRC, RST_OFF_DLY, RST_BT, RST_BT, RST_BT, RST_PLL, RST_ZERO, RST_ZERO, RST_ZERO, RST_ZERO};
  // Stream lengths in data bytes after the opcode
  localparam logic [12:0] PIXEL_BYTES = 13'h1720;
  localparam logic [12:0] LUT_COMMON_BYTES = 13'h002c;
  localparam logic [12:0] LUT_PIXEL_BYTES = 13'h002a;
  // Stream target codes
  localparam logic [2:0] TGT_BW = 3'h0;
  localparam logic [2:0] TGT_RED = 3'h1;
  localparam logic [2:0] TGT_LUT_BASE = 3'h2;
  // Serial frame lengths
  localparam logic [3:0] BITS_4WIRE = 4'h8;
  localparam logic [3:0] BITS_3WIRE = 4'h9;
  // Decoder states
  typedef enum logic [3:0] {
    S_IDLE = 4'b0001,
    S_PARAM = 4'b0010,
    S_STREAM = 4'b0100,
    S_SENSOR = 4'b1000
  } dcd_state_type;
endpackage

/* verif/dcd_host_model.sv */
// Host serial master model for the decoder's link pins
`timescale 1ns/1ns
module dcd_host_model (
  // Link pins
  input wire logic interface_strap,
  input wire logic link_sdo,
  output logic link_sclk,
  output logic link_cs_n,
  output logic link_dc,
  output logic link_sdi
);
  // Clock parked low, select released at start
  initial begin
    link_sclk = 1'b0;
    link_cs_n = 1'b1;
    link_dc = 1'b1;
    link_sdi = 1'b0;
  end
  // Two edges with select high so a new strap level settles
  task automatic warm();
    repeat (2) begin
      #40 link_sclk = 1'b1;
      #40 link_sclk = 1'b0;
    end
  endtask
  // One mode 0 frame, MSB first; select driven low for it and left low when sel is set, else held high throughout so the frame is ignored
  task automatic xfer(input logic dc, input logic [7:0] din, input logic sel, output logic [7:0] dout);
    logic [8:0] sh;
    sh = {dc, din};
    #13 link_cs_n = ~sel;
    link_dc = dc;
    for (int i = interface_strap ? 8 : 7; i >= 0; i--) begin
      link_sdi = sh[i];
      #40 link_sclk = 1'b1;
      dout = {dout[6:0], link_sdo};
      #40 link_sclk = 1'b0;
    end
    // Line left changing so a stale bit is never mistaken for data
    link_sdi = ~link_sdi;
  endtask
  // Release select between sequences
  task automatic idle();
    #40 link_cs_n = 1'b1;
    #40;
  endtask
endmodule // dcd_host_model

/* verif/test_display_command_decoder.sv */
// Self-checking bench for the command decoder
`timescale 1ns/1ns
module test_display_command_decoder;
  logic clock, srst, hw_reset_n, interface_strap, link_sclk, link_cs_n, link_dc, link_sdi;
  logic link_sdo, link_sdo_oe_n, busy_n, sensor_write_req, sensor_read_req, stream_valid;
  logic [7:0] panel_config, booster_phase_a, booster_phase_b, temp_reading_high, stream_data, d;
  logic [7:0] sensor_attr_byte, sensor_wr_high, sensor_wr_low, sensor_rd_high, sensor_rd_low;
  logic [5:0] positive_source_level, negative_source_level, red_source_level, booster_phase_c, frame_clock_divider;
  logic [4:0] temp_source_select;
  logic [2:0] power_level_select, temp_reading_low, stream_target;
  logic [1:0] power_rail_enables, poweroff_source_delay;
  logic [12:0] stream_index;
  logic sensor_done = 1'b0;
  logic stream_ready = 1'b0;
  logic [23:0] q[$];
  integer err_total = 0;
  integer checked = 0;
  wire logic [65:0] cfg = {panel_config, power_rail_enables, power_level_select, positive_source_level,
    negative_source_level, red_source_level, poweroff_source_delay, booster_phase_a, booster_phase_b,
    booster_phase_c, frame_clock_divider, temp_source_select};
  localparam logic [65:0] CFG_DEF = {8'h0f, 2'h3, 3'h0, 6'h26, 6'h26, 6'h03, 2'h0, 8'h17, 8'h17, 6'h17,
    6'h3c, 5'h00};
  dcd_command_decoder dcd_command_decoder_inst (.*);
  dcd_host_model dcd_host_model_inst (.*);
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  // Sensor answers one cycle after a request shows
  always @(negedge clock) sensor_done <= (sensor_write_req | sensor_read_req) & ~sensor_done;
  // Receiver stalls every other cycle so the buffer must hold words
  always @(negedge clock) stream_ready <= srst ? 1'b0 : ~stream_ready;
  // Collect every word handed over
  always @(posedge clock) if (stream_valid && stream_ready) q.push_back({stream_target, stream_index, stream_data});
  task automatic chk(input logic [79:0] got, input logic [79:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tx(input logic dc, input logic [7:0] b);
    dcd_host_model_inst.xfer(dc, b, 1'b1, d);
  endtask
  task automatic settle();
    dcd_host_model_inst.idle();
    repeat (10) @(negedge clock);
  endtask
  // Bounded wait for busy to clear; host never talks over it
  task automatic wait_ready();
    int n = 0;
    repeat (10) @(negedge clock);
    while (busy_n !== 1'b1 && n < 200) begin
      @(negedge clock);
      n++;
    end
    chk(busy_n, 1'b1);
  endtask
  task automatic run(input logic [7:0] op, input int n, input logic [2:0] tgt, input int m);
    tx(1'b0, op);
    for (int i = 0; i < n; i++) tx(1'b1, 8'(i) ^ 8'h5a);
    settle();
    chk(q.size(), m);
    for (int i = 0; i < m; i++) chk(q[i], {tgt, 13'(i), 8'(i) ^ 8'h5a});
    q.delete();
  endtask
  task automatic t_params();
    tx(1'b0, dcd_pkg::OP_POWER);
    tx(1'b1, 8'hfe);
    tx(1'b1, 8'hff);
    tx(1'b0, dcd_pkg::OP_PANEL);
    dcd_host_model_inst.xfer(1'b1, 8'h11, 1'b0, d);
    tx(1'b1, 8'h77);
    tx(1'b1, 8'h99);
    tx(1'b0, dcd_pkg::OP_PWR_OFF_SEQ);
    tx(1'b1, 8'h30);
    tx(1'b0, dcd_pkg::OP_PLL);
    tx(1'b1, 8'h15);
    tx(1'b0, dcd_pkg::OP_TEMP_SELECT);
    tx(1'b1, 8'h8a);
    settle();
    chk({power_rail_enables, power_level_select, positive_source_level, panel_config}, 19'h5e677);
    chk({poweroff_source_delay, frame_clock_divider, temp_source_select}, 13'h1aba);
    $display("params done");
  endtask
  task automatic t_strap3();
    interface_strap = 1'b1;
    dcd_host_model_inst.warm();
    tx(1'b0, dcd_pkg::OP_BOOSTER);
    tx(1'b1, 8'h2b);
    settle();
    chk(booster_phase_a, 8'h2b);
    interface_strap = 1'b0;
    dcd_host_model_inst.warm();
    $display("three-wire done");
  endtask
  task automatic t_stream();
    run(dcd_pkg::OP_BW_FRAME, 3, dcd_pkg::TGT_BW, 3);
    run(dcd_pkg::OP_RED_FRAME, 3, dcd_pkg::TGT_RED, 3);
    run(dcd_pkg::OP_LUT_COMMON, 45, dcd_pkg::TGT_LUT_BASE, 44);
    // Last table overfilled by one byte to show the length limit
    for (int k = 1; k < 5; k++) run(dcd_pkg::OP_LUT_COMMON + 8'(k), (k == 4) ? 43 : 2,
      dcd_pkg::TGT_LUT_BASE + 3'(k), (k == 4) ? 42 : 2);
    $display("stream done");
  endtask
  task automatic t_sensor();
    tx(1'b0, dcd_pkg::OP_SENSOR_WRITE);
    tx(1'b1, 8'hc1);
    tx(1'b1, 8'hc2);
    tx(1'b1, 8'hc3);
    wait_ready();
    chk({sensor_attr_byte, sensor_wr_high, sensor_wr_low}, 24'hc1c2c3);
    tx(1'b0, dcd_pkg::OP_SENSOR_READ);
    wait_ready();
    tx(1'b1, 8'h00);
    chk(d, 8'ha5);
    tx(1'b1, 8'h00);
    chk({link_sdo_oe_n, d}, 9'h03c);
    // Measurement read: low byte keeps its top three bits only
    tx(1'b0, dcd_pkg::OP_TEMP_MEASURE);
    wait_ready();
    tx(1'b1, 8'h00);
    tx(1'b1, 8'h00);
    chk({temp_reading_high, temp_reading_low, d}, 19'h52920);
    settle();
    $display("sensor done");
  endtask
  task automatic t_reset_pin();
    hw_reset_n = 1'b0;
    repeat (4) @(negedge clock);
    hw_reset_n = 1'b1;
    repeat (4) @(negedge clock);
    chk(cfg, CFG_DEF);
    $display("reset pin done");
  endtask
  task automatic results();
    $display("checked=%0d err_total=%0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // Main sequence
  initial begin
    srst = 1'b1;
    hw_reset_n = 1'b1;
    interface_strap = 1'b0;
    sensor_rd_high = 8'ha5;
    sensor_rd_low = 8'h3c;
    repeat (12) @(negedge clock);
    srst = 1'b0;
    repeat (4) @(negedge clock);
    // Link pins settle only once the link clock has run with select high
    dcd_host_model_inst.warm();
    chk(cfg, CFG_DEF);
    chk({busy_n, stream_valid, sensor_write_req, sensor_read_req, link_sdo_oe_n}, 5'h11);
    t_params();
    t_strap3();
    t_stream();
    t_sensor();
    t_reset_pin();
    results();
  end
  // Watchdog sized well past the expected run
  initial begin
    #1500000;
    err_total++;
    results();
  end
endmodule // test_display_command_decoder
